// ### inc/cvb_defines.svh
`ifndef CVB_DEFINES_SVH
`define CVB_DEFINES_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define CVB_ADDR_W 8
`define CVB_OFS_VDO1_CFG 8'h00
`define CVB_OFS_VDO2_CFG 8'h04
`define CVB_OFS_CTRL 8'h08
`define CVB_OFS_SVID_CNT 8'h0c
`define CVB_OFS_VDO1_RD 8'h10
`define CVB_OFS_VDO2_RD 8'h14
`define CVB_OFS_SVID_STAT 8'h18
`define CVB_OFS_SVID_BASE 8'h40

// ************************************************************
// First active cable word fields
// ************************************************************
`define CVB_F_HWFW 31:24
`define CVB_F_VER 23:21
`define CVB_B_VER_CFG 21
`define CVB_B_RSV20 20
`define CVB_F_CONN 19:18
`define CVB_B_CAPTIVE 18
`define CVB_B_RSV17 17
`define CVB_F_LAT 16:13
`define CVB_F_TERM 12:11
`define CVB_B_BOTH_ACT 11
`define CVB_F_VMAX 10:9
`define CVB_B_SBU_N 8
`define CVB_B_SBU_ACT 7
`define CVB_F_CUR 6:5
`define CVB_B_CUR5A 5
`define CVB_B_VBUS 4
`define CVB_B_SOP2 3
`define CVB_F_RSV1 2:0
`define CVB_VER_1_0 3'h0
`define CVB_VER_1_1 3'h1
`define CVB_CONN_PLUG 2'h2
`define CVB_CONN_CAPTIVE 2'h3
`define CVB_LAT_MIN 4'h1
`define CVB_LAT_MAX 4'h8
`define CVB_TERM_ONE 2'h2
`define CVB_TERM_BOTH 2'h3
`define CVB_CUR_RSVD 2'h0
`define CVB_CUR_3A 2'h1
`define CVB_CUR_5A 2'h2

// ************************************************************
// Second active cable word fields
// ************************************************************
`define CVB_F_TMAX 31:24
`define CVB_F_TSHUT 23:16
`define CVB_F_RSV2 15:6
`define CVB_B_USB2_N 5
`define CVB_B_SS_N 4
`define CVB_B_LANES 3
`define CVB_B_RSV2 2
`define CVB_F_GEN 1:0
`define CVB_B_GEN2 0
`define CVB_GEN_1 2'h0
`define CVB_GEN_2 2'h1

// ************************************************************
// SVID words, control, masks and reset values
// ************************************************************
`define CVB_F_SVID_HI 31:16
`define CVB_F_SVID_LO 15:0
`define CVB_SVID_NONE 16'h0000
`define CVB_F_PTYPE 2:0
`define CVB_B_VER12 4
`define CVB_PT_ACTIVE 3'h4
`define CVB_F_STAT_WORDS 15:8
`define CVB_F_STAT_CNT 7:0
`define CVB_VDO1_WMASK 32'hff25_efb8
`define CVB_VDO2_WMASK 32'hffff_0039
`define CVB_CTRL_WMASK 32'h0000_0017
`define CVB_VDO1_RST 32'h0000_2000
`define CVB_VDO2_RST 32'h0000_0000
`define CVB_CTRL_RST 32'h0000_0000

`endif

// ### inc/cvb_pkg.sv
package cvb_pkg;
  // Kind of data object the partner asks for
  typedef enum logic [1:0] {
    CVB_REQ_VDO1,
    CVB_REQ_VDO2,
    CVB_REQ_SVID
  } cvb_req_t;
endpackage

// ### hw/cvb_builder.sv
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "cvb_defines.svh"

module cvb_builder #(
  parameter int SVID_DEPTH = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Discovery request from partner logic
  input wire logic req_valid,
  input wire cvb_pkg::cvb_req_t req_kind,
  input wire logic [7:0] req_index,
  // Data object answer
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  output logic rsp_last,
  output logic rsp_nak
);
  import cvb_pkg::*;

  localparam int IDX_W = $clog2(SVID_DEPTH);
  localparam int CNT_W = IDX_W + 1;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(SVID_DEPTH);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [31:0] vdo1_cfg_r;
  logic [31:0] vdo2_cfg_r;
  logic [31:0] ctrl_r;
  logic [CNT_W-1:0] svid_cnt_r;
  logic [15:0] svid_r [SVID_DEPTH];
  logic wr_pend_r;
  logic rd_pend_r;
  logic [`CVB_ADDR_W-1:0] wr_addr_r;
  logic [`CVB_ADDR_W-1:0] rd_addr_r;
  logic wr_hit_r;
  logic rd_hit_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic rsp_valid_r;
  logic [31:0] rsp_data_r;
  logic rsp_last_r;
  logic rsp_nak_r;
  cvb_req_t rsp_kind_r;

  // ************************************************************
  // Functions
  // ************************************************************
  // First active cable word from the stored settings
  function automatic logic [31:0] build_vdo1(input logic [31:0] c);
    logic [31:0] v;
    v = '0;
    v[`CVB_F_HWFW] = c[`CVB_F_HWFW];
    v[`CVB_F_VER] = c[`CVB_B_VER_CFG] ? `CVB_VER_1_1 : `CVB_VER_1_0;
    v[`CVB_F_CONN] = c[`CVB_B_CAPTIVE] ? `CVB_CONN_CAPTIVE
                                        : `CVB_CONN_PLUG;
    // Latency clamped into the legal code range
    if (c[`CVB_F_LAT] < `CVB_LAT_MIN) begin
      v[`CVB_F_LAT] = `CVB_LAT_MIN;
    end else if (c[`CVB_F_LAT] > `CVB_LAT_MAX) begin
      v[`CVB_F_LAT] = `CVB_LAT_MAX;
    end else begin
      v[`CVB_F_LAT] = c[`CVB_F_LAT];
    end
    v[`CVB_F_TERM] = c[`CVB_B_BOTH_ACT] ? `CVB_TERM_BOTH
                                         : `CVB_TERM_ONE;
    v[`CVB_F_VMAX] = c[`CVB_F_VMAX];
    v[`CVB_B_SBU_N] = c[`CVB_B_SBU_N];
    // Sideband kind only meaningful with wires present
    v[`CVB_B_SBU_ACT] = !c[`CVB_B_SBU_N] && c[`CVB_B_SBU_ACT];
    v[`CVB_B_VBUS] = c[`CVB_B_VBUS];
    // Current field left at zero without VBUS
    if (c[`CVB_B_VBUS]) begin
      v[`CVB_F_CUR] = c[`CVB_B_CUR5A] ? `CVB_CUR_5A : `CVB_CUR_3A;
    end else begin
      v[`CVB_F_CUR] = `CVB_CUR_RSVD;
    end
    v[`CVB_B_SOP2] = c[`CVB_B_SOP2];
    v[`CVB_B_RSV20] = 1'b0;
    v[`CVB_B_RSV17] = 1'b0;
    v[`CVB_F_RSV1] = '0;
    return v;
  endfunction

  // Second active cable word from the stored settings
  function automatic logic [31:0] build_vdo2(input logic [31:0] c);
    logic [31:0] v;
    v = '0;
    v[`CVB_F_TMAX] = c[`CVB_F_TMAX];
    v[`CVB_F_TSHUT] = c[`CVB_F_TSHUT];
    v[`CVB_B_USB2_N] = c[`CVB_B_USB2_N];
    v[`CVB_B_SS_N] = c[`CVB_B_SS_N];
    v[`CVB_B_LANES] = c[`CVB_B_LANES];
    v[`CVB_F_GEN] = c[`CVB_B_GEN2] ? `CVB_GEN_2 : `CVB_GEN_1;
    return v;
  endfunction

  // Number of SVID words, one more than the pair count
  function automatic logic [CNT_W-1:0] svid_words(
    input logic [CNT_W-1:0] cnt
  );
    return (cnt >> 1) + CNT_W'(1);
  endfunction

  // Table slot decode of a register address
  function automatic logic svid_hit(input logic [`CVB_ADDR_W-1:0] a);
    logic [`CVB_ADDR_W-1:0] d;
    d = a - `CVB_OFS_SVID_BASE;
    return (a >= `CVB_OFS_SVID_BASE) && ((d >> 2) < SVID_DEPTH);
  endfunction

  function automatic logic [IDX_W-1:0] svid_slot(
    input logic [`CVB_ADDR_W-1:0] a
  );
    logic [`CVB_ADDR_W-1:0] d;
    d = (a - `CVB_OFS_SVID_BASE) >> 2;
    return d[IDX_W-1:0];
  endfunction

  // ************************************************************
  // Bus address phase and wait state
  // ************************************************************
  logic bus_acc;
  logic bus_hit;
  logic [31:0] wdat;
  logic [31:0] rd_mux;
  logic [31:0] vdo1_now;
  logic [31:0] vdo2_now;
  logic vdo2_ok;
  logic [CNT_W-1:0] words_now;

  assign bus_acc = hsel && htrans[1] && hready;
  assign bus_hit = (haddr[31:`CVB_ADDR_W] == '0);
  assign wdat = hwdata;
  assign vdo1_now = build_vdo1(vdo1_cfg_r);
  assign vdo2_now = build_vdo2(vdo2_cfg_r);
  assign words_now = svid_words(svid_cnt_r);
  assign vdo2_ok = (ctrl_r[`CVB_F_PTYPE] == `CVB_PT_ACTIVE) &&
                   ctrl_r[`CVB_B_VER12];

  // Capture of the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= '0;
      rd_addr_r <= '0;
      wr_hit_r <= 1'b0;
      rd_hit_r <= 1'b0;
    end else begin
      wr_pend_r <= bus_acc && hwrite;
      rd_pend_r <= bus_acc && !hwrite;
      if (bus_acc && hwrite) begin
        wr_addr_r <= haddr[`CVB_ADDR_W-1:0];
        wr_hit_r <= bus_hit;
      end
      if (bus_acc && !hwrite) begin
        rd_addr_r <= haddr[`CVB_ADDR_W-1:0];
        rd_hit_r <= bus_hit;
      end
    end
  end

  // One wait state on reads, none on writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= !(bus_acc && !hwrite);
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vdo1_cfg_r <= `CVB_VDO1_RST;
      vdo2_cfg_r <= `CVB_VDO2_RST;
      ctrl_r <= `CVB_CTRL_RST;
      svid_cnt_r <= '0;
    end else if (wr_pend_r && wr_hit_r) begin
      unique case (wr_addr_r)
        `CVB_OFS_VDO1_CFG: vdo1_cfg_r <= wdat & `CVB_VDO1_WMASK;
        `CVB_OFS_VDO2_CFG: vdo2_cfg_r <= wdat & `CVB_VDO2_WMASK;
        `CVB_OFS_CTRL: ctrl_r <= wdat & `CVB_CTRL_WMASK;
        `CVB_OFS_SVID_CNT: begin
          // Count saturates at the table depth
          if (wdat > 32'(SVID_DEPTH)) begin
            svid_cnt_r <= DEPTH_C;
          end else begin
            svid_cnt_r <= wdat[CNT_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // SVID table entries
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < SVID_DEPTH; i++) begin
        svid_r[i] <= `CVB_SVID_NONE;
      end
    end else if (wr_pend_r && wr_hit_r && svid_hit(wr_addr_r)) begin
      svid_r[svid_slot(wr_addr_r)] <= wdat[`CVB_F_SVID_LO];
    end
  end

  // ************************************************************
  // Register reads
  // ************************************************************
  always_comb begin
    rd_mux = '0;
    if (rd_hit_r) begin
      unique case (rd_addr_r)
        `CVB_OFS_VDO1_CFG: rd_mux = vdo1_cfg_r;
        `CVB_OFS_VDO2_CFG: rd_mux = vdo2_cfg_r;
        `CVB_OFS_CTRL: rd_mux = ctrl_r;
        `CVB_OFS_SVID_CNT: rd_mux = 32'(svid_cnt_r);
        `CVB_OFS_VDO1_RD: rd_mux = vdo1_now;
        `CVB_OFS_VDO2_RD: rd_mux = vdo2_ok ? vdo2_now : '0;
        `CVB_OFS_SVID_STAT: begin
          rd_mux[`CVB_F_STAT_WORDS] = 8'(words_now);
          rd_mux[`CVB_F_STAT_CNT] = 8'(svid_cnt_r);
        end
        default: begin
          if (svid_hit(rd_addr_r)) begin
            rd_mux[`CVB_F_SVID_LO] = svid_r[svid_slot(rd_addr_r)];
          end
        end
      endcase
    end
  end

  // Read data loaded during the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (rd_pend_r) begin
      hrdata_r <= rd_mux;
    end
  end

  // ************************************************************
  // Discovery answers
  // ************************************************************
  logic [CNT_W:0] hi_idx;
  logic [CNT_W:0] lo_idx;
  assign hi_idx = {req_index[CNT_W-1:0], 1'b0};
  assign lo_idx = hi_idx + (CNT_W+1)'(1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= '0;
      rsp_last_r <= 1'b0;
      rsp_nak_r <= 1'b0;
      rsp_kind_r <= CVB_REQ_VDO1;
    end else begin
      rsp_valid_r <= req_valid;
      if (req_valid) begin
        rsp_kind_r <= req_kind;
        rsp_data_r <= '0;
        rsp_last_r <= 1'b1;
        rsp_nak_r <= 1'b0;
        unique case (req_kind)
          CVB_REQ_VDO1: rsp_data_r <= vdo1_now;
          CVB_REQ_VDO2: begin
            // Refused unless active cable at version 1.2
            if (vdo2_ok) begin
              rsp_data_r <= vdo2_now;
            end else begin
              rsp_nak_r <= 1'b1;
            end
          end
          CVB_REQ_SVID: begin
            if (9'(req_index) < 9'(words_now)) begin
              rsp_last_r <= (9'(req_index) == 9'(words_now) - 9'd1);
              // Entry 2n high, 2n+1 low, zero past the count
              if (hi_idx < (CNT_W+1)'(svid_cnt_r)) begin
                rsp_data_r[`CVB_F_SVID_HI] <=
                  svid_r[hi_idx[IDX_W-1:0]];
              end else begin
                rsp_data_r[`CVB_F_SVID_HI] <= `CVB_SVID_NONE;
              end
              if (lo_idx < (CNT_W+1)'(svid_cnt_r)) begin
                rsp_data_r[`CVB_F_SVID_LO] <=
                  svid_r[lo_idx[IDX_W-1:0]];
              end else begin
                rsp_data_r[`CVB_F_SVID_LO] <= `CVB_SVID_NONE;
              end
            end else begin
              rsp_nak_r <= 1'b1;
            end
          end
          default: rsp_nak_r <= 1'b1;
        endcase
      end
    end
  end

  // Outputs from flops, hresp tied low
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_last = rsp_last_r;
  assign rsp_nak = rsp_nak_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic v1_out;
  logic v2_out;
  logic sv_out;
  assign v1_out = rsp_valid && rsp_kind_r == CVB_REQ_VDO1;
  assign v2_out = rsp_valid && rsp_kind_r == CVB_REQ_VDO2 && !rsp_nak;
  assign sv_out = rsp_valid && rsp_kind_r == CVB_REQ_SVID && !rsp_nak;

  rsp_timing_a: assert property (req_valid |=> rsp_valid)
    else $error("answer not one cycle after request");
  version_code_a: assert property (
    v1_out |-> rsp_data[`CVB_F_VER] <= `CVB_VER_1_1)
    else $error("reserved version code sent");
  vdo1_reserved_a: assert property (
    v1_out |-> !rsp_data[`CVB_B_RSV20] && !rsp_data[`CVB_B_RSV17] &&
               rsp_data[`CVB_F_RSV1] == '0)
    else $error("first word reserved bit set");
  connector_code_a: assert property (
    v1_out |-> rsp_data[`CVB_F_CONN] ==
      ($past(vdo1_cfg_r[`CVB_B_CAPTIVE]) ? `CVB_CONN_CAPTIVE
                                         : `CVB_CONN_PLUG))
    else $error("connector code wrong");
  latency_range_a: assert property (
    v1_out |-> rsp_data[`CVB_F_LAT] inside {[`CVB_LAT_MIN:`CVB_LAT_MAX]})
    else $error("latency code out of range");
  term_code_a: assert property (
    v1_out |-> rsp_data[`CVB_F_TERM] inside {`CVB_TERM_ONE,
                                             `CVB_TERM_BOTH})
    else $error("termination code reserved");
  vmax_follow_a: assert property (
    v1_out |-> rsp_data[`CVB_F_VMAX] == $past(vdo1_cfg_r[`CVB_F_VMAX]))
    else $error("voltage field not from settings");
  sbu_flags_a: assert property (
    v1_out |-> rsp_data[`CVB_B_SBU_N] == $past(vdo1_cfg_r[`CVB_B_SBU_N]))
    else $error("sideband flag not from settings");
  sbu_ignore_a: assert property (
    v1_out && rsp_data[`CVB_B_SBU_N] |-> !rsp_data[`CVB_B_SBU_ACT])
    else $error("sideband kind set without wires");
  current_code_a: assert property (
    v1_out |-> (rsp_data[`CVB_B_VBUS]
      ? rsp_data[`CVB_F_CUR] inside {`CVB_CUR_3A, `CVB_CUR_5A}
      : rsp_data[`CVB_F_CUR] == `CVB_CUR_RSVD))
    else $error("current code wrong");
  sop2_flag_a: assert property (
    v1_out |-> rsp_data[`CVB_B_SOP2] == $past(vdo1_cfg_r[`CVB_B_SOP2]))
    else $error("second controller flag wrong");
  vdo2_gate_a: assert property (
    req_valid && req_kind == CVB_REQ_VDO2 |=> rsp_nak == !$past(vdo2_ok))
    else $error("second word gating wrong");
  vdo2_fields_a: assert property (
    v2_out |-> rsp_data[`CVB_F_TMAX] == $past(vdo2_cfg_r[`CVB_F_TMAX]) &&
      rsp_data[`CVB_F_TSHUT] == $past(vdo2_cfg_r[`CVB_F_TSHUT]) &&
      rsp_data[`CVB_F_RSV2] == '0 && !rsp_data[`CVB_B_RSV2] &&
      !rsp_data[1])
    else $error("second word field wrong");
  svid_end_a: assert property (
    sv_out && rsp_last |-> rsp_data[`CVB_F_SVID_HI] == `CVB_SVID_NONE ||
      rsp_data[`CVB_F_SVID_LO] == `CVB_SVID_NONE ||
      $past(svid_cnt_r) == DEPTH_C)
    else $error("list end not padded");

  read_seen_c: cover property (rd_pend_r ##1 hreadyout);
  vdo2_sent_c: cover property (v2_out);
  svid_last_c: cover property (sv_out && rsp_last);
endmodule

// ### dv/cvb_initiator.sv
`timescale 1ns/10ps
// ************************************************************
// Discovery initiator model: issues requests, catches answers
// ************************************************************
module cvb_initiator (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request out
  output logic req_valid,
  output cvb_pkg::cvb_req_t req_kind,
  output logic [7:0] req_index,
  // Answer in
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_nak
);
  import cvb_pkg::*;

  // Idle request lines at time zero
  initial begin
    req_valid = 1'b0;
    req_kind = CVB_REQ_VDO1;
    req_index = 8'h00;
  end

  // One request pulse; answer sampled in its one-cycle slot
  task automatic ask(input cvb_req_t k, input logic [7:0] idx,
      output logic v, output logic [31:0] d, output logic l,
      output logic n);
    @(posedge hclk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_index <= idx;
    @(posedge hclk);
    req_valid <= 1'b0;
    req_kind <= cvb_req_t'(~k); // Released lines do not keep old value
    req_index <= ~idx;
    #1;
    v = rsp_valid;
    d = rsp_data;
    l = rsp_last;
    n = rsp_nak;
  endtask
endmodule

// ### dv/tb_cable_vdo_builder.sv
`timescale 1ns/10ps
`include "cvb_defines.svh"
// ************************************************************
// Bench for the cable data object builder
// ************************************************************
module tb_cable_vdo_builder;
  import cvb_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rsp_data;
  logic req_valid, rsp_valid, rsp_last, rsp_nak;
  cvb_req_t req_kind;
  logic [7:0] req_index;
  int failures;
  int cmp_count;

  // Design and partner
  cvb_builder #(.SVID_DEPTH(8)) i_cvb_builder (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .req_valid(req_valid), .req_kind(req_kind),
    .req_index(req_index), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .rsp_nak(rsp_nak));
  cvb_initiator i_cvb_initiator (
    .hclk(hclk), .hresetn(hresetn), .req_valid(req_valid),
    .req_kind(req_kind), .req_index(req_index), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_nak(rsp_nak));

  // 25 MHz clock
  always #20 hclk = ~hclk;

  // ************************************************************
  // Common tasks
  // ************************************************************
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      $display("BAD %0t bus wait ran out", $time);
      final_report();
    end
  endtask

  // One single-word transfer, address then data phase
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    // Finished bus lines show a changed value, not the last one
    haddr <= ~{24'h0, a};
    hwrite <= ~w;
    hwdata <= ~wd;
    chk({31'h0, hresp}, 32'h0, "response not okay");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
      input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e, what);
  endtask

  // Request through the partner and judge the answer
  task automatic req(input cvb_req_t k, input logic [7:0] idx,
      input logic [31:0] ed, input logic el, input logic en,
      input string what);
    logic v, l, n;
    logic [31:0] d;
    i_cvb_initiator.ask(k, idx, v, d, l, n);
    chk({30'h0, v, n}, {30'h0, 1'b1, en}, what);
    chk(d, ed, what);
    if (!en) begin
      chk({31'h0, l}, {31'h0, el}, what);
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    rdc(`CVB_OFS_VDO1_RD, 32'h0008_3000, "first word at reset");
    rdc(`CVB_OFS_VDO2_RD, 32'h0, "second word at reset");
    rdc(8'h3c, 32'h0, "unmapped read");
    req(CVB_REQ_VDO2, 8'h00, 32'h0, 1'b1, 1'b1, "second gated");
    req(CVB_REQ_SVID, 8'h00, 32'h0, 1'b1, 1'b0, "empty list");
    req(CVB_REQ_SVID, 8'h01, 32'h0, 1'b1, 1'b1, "past empty list");
    $display("t_reset done");
  endtask

  // Write all settings plus reserved ones, expect the built word
  task automatic chk_v1(input logic [7:0] hw, input logic ver,
      input logic cap, input logic [3:0] lat, input logic both,
      input logic [1:0] vmax, input logic sbn, input logic sba,
      input logic c5, input logic vb, input logic s2);
    logic [3:0] lx;
    logic [31:0] e;
    lx = (lat == 4'h0) ? 4'h1 : (lat > 4'h8) ? 4'h8 : lat;
    e = {hw, 2'b00, ver, 1'b0, 1'b1, cap, 1'b0, lx, 1'b1, both, vmax,
      sbn, sbn ? 1'b0 : sba, vb ? {c5, ~c5} : 2'b00, vb, s2, 3'b000};
    wr(`CVB_OFS_VDO1_CFG, {hw, 2'b11, ver, 2'b11, cap, 1'b1, lat, 1'b1,
      both, vmax, sbn, sba, 1'b1, c5, vb, s2, 3'b111});
    rdc(`CVB_OFS_VDO1_RD, e, "first word register");
    req(CVB_REQ_VDO1, 8'h00, e, 1'b1, 1'b0, "first word answer");
  endtask

  task automatic t_vdo1;
    chk_v1(8'ha5, 1, 1, 4'h0, 1, 2'h3, 0, 1, 1, 1, 1);
    chk_v1(8'h3c, 0, 0, 4'h9, 0, 2'h0, 1, 1, 1, 0, 0);
    chk_v1(8'h00, 0, 0, 4'h8, 1, 2'h1, 0, 0, 0, 1, 0);
    chk_v1(8'hff, 1, 1, 4'hf, 0, 2'h2, 0, 1, 1, 1, 0);
    chk_v1(8'h5a, 0, 1, 4'h1, 1, 2'h0, 1, 0, 0, 1, 1);
    $display("t_vdo1 done");
  endtask

  task automatic chk_v2(input logic [7:0] tmax, input logic [7:0] tsd,
      input logic u2, input logic ss, input logic ln, input logic g2);
    logic [31:0] e;
    e = {tmax, tsd, 10'h0, u2, ss, ln, 1'b0, 1'b0, g2};
    wr(`CVB_OFS_VDO2_CFG, {tmax, tsd, 10'h3ff, u2, ss, ln, 2'b11, g2});
    rdc(`CVB_OFS_VDO2_RD, e, "second word register");
    req(CVB_REQ_VDO2, 8'h00, e, 1'b1, 1'b0, "second word");
  endtask

  task automatic t_vdo2;
    wr(`CVB_OFS_CTRL, 32'hffff_ffff);
    rdc(`CVB_OFS_CTRL, 32'h0000_0017, "control mask");
    wr(`CVB_OFS_CTRL, 32'h0000_0014);
    chk_v2(8'h5a, 8'h4b, 0, 1, 1, 1);
    chk_v2(8'h7f, 8'h80, 1, 0, 0, 0);
    wr(`CVB_OFS_CTRL, 32'h0000_0004);
    req(CVB_REQ_VDO2, 8'h00, 32'h0, 1'b1, 1'b1, "no version");
    rdc(`CVB_OFS_VDO2_RD, 32'h0, "second word hidden");
    wr(`CVB_OFS_CTRL, 32'h0000_0013);
    req(CVB_REQ_VDO2, 8'h00, 32'h0, 1'b1, 1'b1, "not active");
    req(cvb_req_t'(2'h3), 8'h00, 32'h0, 1'b1, 1'b1, "illegal kind");
    $display("t_vdo2 done");
  endtask

  task automatic t_svid;
    wr(`CVB_OFS_SVID_CNT, 32'h0000_0003);
    wr(`CVB_OFS_SVID_BASE, 32'hffff_1111);
    wr(`CVB_OFS_SVID_BASE + 8'h04, 32'h0000_2222);
    wr(`CVB_OFS_SVID_BASE + 8'h08, 32'h0000_3333);
    rdc(`CVB_OFS_SVID_STAT, 32'h0000_0203, "list status odd");
    req(CVB_REQ_SVID, 8'h00, 32'h1111_2222, 0, 0, "pair");
    req(CVB_REQ_SVID, 8'h01, 32'h3333_0000, 1, 0, "odd end");
    req(CVB_REQ_SVID, 8'h02, 32'h0, 1'b1, 1'b1, "past odd end");
    wr(`CVB_OFS_SVID_CNT, 32'h0000_0004);
    wr(`CVB_OFS_SVID_BASE + 8'h0c, 32'h0000_4444);
    req(CVB_REQ_SVID, 8'h01, 32'h3333_4444, 0, 0, "second pair");
    req(CVB_REQ_SVID, 8'h02, 32'h0, 1'b1, 1'b0, "even end");
    wr(`CVB_OFS_SVID_CNT, 32'h0000_00ff);
    rdc(`CVB_OFS_SVID_STAT, 32'h0000_0508, "list status full");
    req(CVB_REQ_SVID, 8'h04, 32'h0, 1'b1, 1'b0, "full end");
    $display("t_svid done");
  endtask

  // Reset in mid-run returns settings and table to reset values
  task automatic t_rerst;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({31'h0, rsp_valid}, 32'h0, "answer in reset");
    hresetn <= 1'b1;
    rdc(`CVB_OFS_VDO1_RD, 32'h0008_3000, "first word again");
    rdc(`CVB_OFS_SVID_STAT, 32'h0000_0100, "list status again");
    rdc(`CVB_OFS_SVID_BASE, 32'h0, "table entry cleared");
    req(CVB_REQ_SVID, 8'h00, 32'h0, 1'b1, 1'b0, "empty list again");
    $display("t_rerst done");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    failures = 0;
    cmp_count = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_vdo1();
    t_vdo2();
    t_svid();
    t_rerst();
    final_report();
  end
endmodule
